//--- verilog/charger_regs_pkg.sv
// constants shared by the charger control, status and fault registers
package charger_regs_pkg;
   localparam logic [7:0] MISC_OPERATION_CONTROL_ADDR = 8'h07;
   localparam logic [7:0] SYSTEM_STATUS_ADDR = 8'h08;
   localparam logic [7:0] LATCHED_FAULT_ADDR = 8'h09;
   localparam logic [7:0] MISC_OPERATION_CONTROL_RESET = 8'h4b;
   localparam logic [7:0] LATCHED_FAULT_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // control field positions
   localparam int FORCE_SOURCE_DETECT_BIT = 7;
   localparam int TIMER_SLOWDOWN_ENABLE_BIT = 6;
   localparam int BATTERY_SWITCH_OFF_BIT = 5;
   localparam int CHARGE_FAULT_INT_ENABLE_BIT = 1;
   localparam int BATTERY_FAULT_INT_ENABLE_BIT = 0;
   // fault field positions
   localparam int WATCHDOG_FAULT_BIT = 7;
   localparam int BOOST_FAULT_BIT = 6;
   localparam int CHARGE_FAULT_HI = 5;
   localparam int CHARGE_FAULT_LO = 4;
   localparam int BATTERY_OVERVOLTAGE_FAULT_BIT = 3;
   localparam int FAULT_RESERVED_BIT = 2;
   localparam int TEMP_COLD_BIT = 1;
   localparam int TEMP_HOT_BIT = 0;
   // charge fault codes
   localparam logic [1:0] CHARGE_FAULT_NORMAL = 2'h0;
   localparam logic [1:0] CHARGE_FAULT_INPUT = 2'h1;
   localparam logic [1:0] CHARGE_FAULT_THERMAL = 2'h2;
   localparam logic [1:0] CHARGE_FAULT_TIMER = 2'h3;
   // battery switch turn-off delay, window 7 s to 11 s
   localparam int unsigned CLOCK_HZ = 100000000;
   localparam int unsigned BATTERY_SWITCH_OFF_MIN_S = 7;
   localparam int unsigned BATTERY_SWITCH_OFF_MAX_S = 11;
   localparam logic [31:0] BATTERY_SWITCH_OFF_DELAY_CYCLES = 32'(BATTERY_SWITCH_OFF_MIN_S * CLOCK_HZ);
   localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;
   localparam logic [31:0] COUNT_ONE = 32'h0000_0001;
endpackage

//--- verilog/battery_switch_delay.sv
// delayed turn-off of the battery switch
module battery_switch_delay #(
   parameter logic [31:0] DELAY_CYCLES = charger_regs_pkg::BATTERY_SWITCH_OFF_DELAY_CYCLES
)
(
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic switch_off_request_in,
   output logic battery_switch_on_out
);
   logic [31:0] count;
   logic [31:0] next_count;
   logic next_battery_switch_on;

   always_comb
   begin
      next_count = count;
      next_battery_switch_on = battery_switch_on_out;
      if (!switch_off_request_in)
      begin
         // clearing the request restores the switch at once and restarts the delay
         next_count = charger_regs_pkg::COUNT_ZERO;
         next_battery_switch_on = 1'b1;
      end
      else if (count < DELAY_CYCLES - charger_regs_pkg::COUNT_ONE)
      begin
         next_count = count + charger_regs_pkg::COUNT_ONE;
      end
      else
      begin
         next_battery_switch_on = 1'b0;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         count <= charger_regs_pkg::COUNT_ZERO;
         battery_switch_on_out <= 1'b1;
      end
      else
      begin
         count <= next_count;
         battery_switch_on_out <= next_battery_switch_on;
      end
   end
endmodule // battery_switch_delay

//--- verilog/charger_status_fault_regs.sv
// control, live status and latched fault registers of the charger
//
// Function
// - forced source detect bit runs detection with input power, self-clears when done.
// - slowdown enabled halves safety timer rate during input limiting or thermal regulation.
// - battery switch off bit turns switch off after 7 to 11 seconds.
// - control bit 1 enables interrupt on charge faults, reset one.
// - control bit 0 enables interrupt on battery overvoltage fault, reset one.
// - status bits 7:6 give input source: none, usb host, adapter, otg.
// - status bits 5:4 give charge state: idle, pre-charge, fast, terminated.
// - status bit 3 reads one while input voltage or current is limited.
// - status bit 2 reads one when input power is good.
// - status bit 1 reads one during thermal regulation.
// - status bit 0 reads one while regulating minimum system voltage.
// - fault bit 7 latches watchdog expiry.
// - fault bit 6 latches any condition stopping boost operation.
// - fault bits 5:4 hold charge fault code: input, thermal, timer.
// - fault bit 3 latches battery overvoltage; bit 2 reads zero.
// - fault bits 1 and 0 flag cold and hot battery, mode dependent thresholds.
// - faults latched; read returns and clears, then reloads still-present faults.
// - adapter removal sets charge fault code to input fault once.
// - control register resets to 4b.
module charger_status_fault_regs #(
   parameter logic [31:0] BATTERY_SWITCH_OFF_DELAY_CYCLES = charger_regs_pkg::BATTERY_SWITCH_OFF_DELAY_CYCLES
)
(
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   input wire logic vbus_present_in,
   input wire logic detect_done_in,
   output logic detect_start_out,
   input wire logic safety_tick_in,
   output logic safety_tick_out,
   input wire logic [1:0] input_source_status_in,
   input wire logic [1:0] charge_state_in,
   input wire logic input_limit_active_in,
   input wire logic input_power_good_in,
   input wire logic thermal_regulation_active_in,
   input wire logic min_system_regulation_active_in,
   input wire logic watchdog_expired_in,
   input wire logic boost_fault_in,
   input wire logic [1:0] charge_fault_code_in,
   input wire logic battery_overvoltage_in,
   input wire logic temp_cold_in,
   input wire logic temp_hot_in,
   input wire logic boost_mode_in,
   input wire logic adapter_removed_in,
   output logic temp_threshold_boost_out,
   output logic battery_switch_on_out,
   output logic fault_irq_out
);
   typedef enum logic [1:0] {DETECT_IDLE, DETECT_WAIT_POWER, DETECT_RUNNING} detect_state_t;

   logic [7:0] misc_operation_control;
   logic [7:0] next_misc_operation_control;
   logic [7:0] latched_fault;
   logic [7:0] next_latched_fault;
   logic [7:0] system_status;
   logic [7:0] present_fault;
   logic [7:0] new_fault;
   logic [7:0] next_reg_rdata;
   logic next_reg_rvalid;
   logic next_fault_irq;
   detect_state_t detect_state;
   detect_state_t next_detect_state;
   logic next_detect_start;
   logic tick_phase;
   logic next_tick_phase;
   logic next_safety_tick;
   logic next_temp_threshold_boost;
   logic ctrl_write;
   logic fault_read;
   logic slow_active;

   assign ctrl_write = reg_wr_in && (reg_addr_in == charger_regs_pkg::MISC_OPERATION_CONTROL_ADDR);
   // a burst would clear faults it never returns, so reads are single bytes only
   assign fault_read = reg_rd_in && (reg_addr_in == charger_regs_pkg::LATCHED_FAULT_ADDR);

   // live status, sampled at read time
   always_comb
   begin
      system_status = {input_source_status_in,
                       charge_state_in,
                       input_limit_active_in,
                       input_power_good_in,
                       thermal_regulation_active_in,
                       min_system_regulation_active_in};
   end

   // faults as they stand now
   always_comb
   begin
      present_fault = 8'h00;
      present_fault[charger_regs_pkg::WATCHDOG_FAULT_BIT] = watchdog_expired_in;
      present_fault[charger_regs_pkg::BOOST_FAULT_BIT] = boost_fault_in;
      present_fault[charger_regs_pkg::CHARGE_FAULT_HI:charger_regs_pkg::CHARGE_FAULT_LO] = charge_fault_code_in;
      if (adapter_removed_in && charge_fault_code_in == charger_regs_pkg::CHARGE_FAULT_NORMAL)
      begin
         present_fault[charger_regs_pkg::CHARGE_FAULT_HI:charger_regs_pkg::CHARGE_FAULT_LO] =
            charger_regs_pkg::CHARGE_FAULT_INPUT;
      end
      present_fault[charger_regs_pkg::BATTERY_OVERVOLTAGE_FAULT_BIT] = battery_overvoltage_in;
      present_fault[charger_regs_pkg::FAULT_RESERVED_BIT] = 1'b0;
      present_fault[charger_regs_pkg::TEMP_COLD_BIT] = temp_cold_in;
      present_fault[charger_regs_pkg::TEMP_HOT_BIT] = temp_hot_in;
   end

   // fault latch and its read-to-clear
   always_comb
   begin
      next_latched_fault = latched_fault;
      if (fault_read)
      begin
         // faults arriving in the read cycle survive the clear
         next_latched_fault = present_fault;
      end
      else
      begin
         next_latched_fault = latched_fault | present_fault;
         next_latched_fault[charger_regs_pkg::CHARGE_FAULT_HI:charger_regs_pkg::CHARGE_FAULT_LO] =
            latched_fault[charger_regs_pkg::CHARGE_FAULT_HI:charger_regs_pkg::CHARGE_FAULT_LO];
         // the first charge fault code is kept until read
         if (latched_fault[charger_regs_pkg::CHARGE_FAULT_HI:charger_regs_pkg::CHARGE_FAULT_LO] ==
             charger_regs_pkg::CHARGE_FAULT_NORMAL)
         begin
            next_latched_fault[charger_regs_pkg::CHARGE_FAULT_HI:charger_regs_pkg::CHARGE_FAULT_LO] =
               present_fault[charger_regs_pkg::CHARGE_FAULT_HI:charger_regs_pkg::CHARGE_FAULT_LO];
         end
      end
      next_latched_fault[charger_regs_pkg::FAULT_RESERVED_BIT] = 1'b0;
   end

   // interrupt on newly latched faults
   always_comb
   begin
      new_fault = next_latched_fault & ~latched_fault;
      if (fault_read)
      begin
         // after a clear every reloaded fault counts as new
         new_fault = next_latched_fault;
      end
      next_fault_irq = new_fault[charger_regs_pkg::WATCHDOG_FAULT_BIT] ||
                       new_fault[charger_regs_pkg::BOOST_FAULT_BIT] ||
                       new_fault[charger_regs_pkg::TEMP_COLD_BIT] ||
                       new_fault[charger_regs_pkg::TEMP_HOT_BIT];
      if (misc_operation_control[charger_regs_pkg::CHARGE_FAULT_INT_ENABLE_BIT] &&
          (new_fault[charger_regs_pkg::CHARGE_FAULT_HI:charger_regs_pkg::CHARGE_FAULT_LO] !=
           charger_regs_pkg::CHARGE_FAULT_NORMAL))
      begin
         next_fault_irq = 1'b1;
      end
      if (misc_operation_control[charger_regs_pkg::BATTERY_FAULT_INT_ENABLE_BIT] &&
          new_fault[charger_regs_pkg::BATTERY_OVERVOLTAGE_FAULT_BIT])
      begin
         next_fault_irq = 1'b1;
      end
   end

   // control register and forced detection sequence
   always_comb
   begin
      next_misc_operation_control = misc_operation_control;
      next_detect_state = detect_state;
      next_detect_start = 1'b0;
      if (ctrl_write)
      begin
         // reserved bits are stored and read back as written
         next_misc_operation_control = reg_wdata_in;
      end
      case (detect_state)
         DETECT_IDLE:
         begin
            if (misc_operation_control[charger_regs_pkg::FORCE_SOURCE_DETECT_BIT])
            begin
               next_detect_state = DETECT_WAIT_POWER;
            end
         end
         DETECT_WAIT_POWER:
         begin
            if (!misc_operation_control[charger_regs_pkg::FORCE_SOURCE_DETECT_BIT])
            begin
               next_detect_state = DETECT_IDLE;
            end
            else if (vbus_present_in)
            begin
               // without input power the request waits rather than being dropped
               next_detect_start = 1'b1;
               next_detect_state = DETECT_RUNNING;
            end
         end
         DETECT_RUNNING:
         begin
            if (ctrl_write && reg_wdata_in[charger_regs_pkg::FORCE_SOURCE_DETECT_BIT])
            begin
               // a fresh request in the completion cycle restarts detection
               next_detect_state = DETECT_WAIT_POWER;
            end
            else if (!misc_operation_control[charger_regs_pkg::FORCE_SOURCE_DETECT_BIT])
            begin
               next_detect_state = DETECT_IDLE;
            end
            else if (detect_done_in)
            begin
               next_misc_operation_control[charger_regs_pkg::FORCE_SOURCE_DETECT_BIT] = 1'b0;
               next_detect_state = DETECT_IDLE;
            end
         end
         default:
         begin
            next_detect_state = DETECT_IDLE;
         end
      endcase
   end

   // safety timer tick, halved under input limiting or thermal regulation
   always_comb
   begin
      slow_active = misc_operation_control[charger_regs_pkg::TIMER_SLOWDOWN_ENABLE_BIT] &&
                    (input_limit_active_in || thermal_regulation_active_in);
      next_tick_phase = tick_phase;
      next_safety_tick = 1'b0;
      if (safety_tick_in)
      begin
         if (slow_active)
         begin
            next_tick_phase = ~tick_phase;
            next_safety_tick = tick_phase;
         end
         else
         begin
            next_tick_phase = 1'b0;
            next_safety_tick = 1'b1;
         end
      end
   end

   // read port, one cycle latency
   always_comb
   begin
      next_reg_rvalid = reg_rd_in;
      next_reg_rdata = charger_regs_pkg::READ_UNMAPPED;
      if (reg_addr_in == charger_regs_pkg::MISC_OPERATION_CONTROL_ADDR)
      begin
         next_reg_rdata = misc_operation_control;
      end
      else if (reg_addr_in == charger_regs_pkg::SYSTEM_STATUS_ADDR)
      begin
         next_reg_rdata = system_status;
      end
      else if (reg_addr_in == charger_regs_pkg::LATCHED_FAULT_ADDR)
      begin
         next_reg_rdata = latched_fault;
      end
      if (!reg_rd_in)
      begin
         next_reg_rdata = reg_rdata_out;
      end
      // comparator thresholds follow the converter mode
      next_temp_threshold_boost = boost_mode_in;
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         misc_operation_control <= charger_regs_pkg::MISC_OPERATION_CONTROL_RESET;
         latched_fault <= charger_regs_pkg::LATCHED_FAULT_RESET;
         detect_state <= DETECT_IDLE;
         detect_start_out <= 1'b0;
         tick_phase <= 1'b0;
         safety_tick_out <= 1'b0;
         reg_rdata_out <= charger_regs_pkg::READ_UNMAPPED;
         reg_rvalid_out <= 1'b0;
         fault_irq_out <= 1'b0;
         temp_threshold_boost_out <= 1'b0;
      end
      else
      begin
         misc_operation_control <= next_misc_operation_control;
         latched_fault <= next_latched_fault;
         detect_state <= next_detect_state;
         detect_start_out <= next_detect_start;
         tick_phase <= next_tick_phase;
         safety_tick_out <= next_safety_tick;
         reg_rdata_out <= next_reg_rdata;
         reg_rvalid_out <= next_reg_rvalid;
         fault_irq_out <= next_fault_irq;
         temp_threshold_boost_out <= next_temp_threshold_boost;
      end
   end

   battery_switch_delay #(
      .DELAY_CYCLES(BATTERY_SWITCH_OFF_DELAY_CYCLES)
   ) u_battery_switch_delay (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .switch_off_request_in(misc_operation_control[charger_regs_pkg::BATTERY_SWITCH_OFF_BIT]),
      .battery_switch_on_out(battery_switch_on_out)
   );
endmodule // charger_status_fault_regs

//--- dv/charger_regs_monitor.sv
// port assertions for the charger control, status and fault registers
module charger_regs_monitor (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   input wire logic vbus_present_in,
   input wire logic detect_start_out,
   input wire logic safety_tick_in,
   input wire logic safety_tick_out,
   input wire logic [1:0] input_source_status_in,
   input wire logic [1:0] charge_state_in,
   input wire logic input_limit_active_in,
   input wire logic input_power_good_in,
   input wire logic thermal_regulation_active_in,
   input wire logic min_system_regulation_active_in,
   input wire logic boost_mode_in,
   input wire logic temp_threshold_boost_out,
   input wire logic battery_switch_on_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_wr_ctrl;
      reg_wr_in && reg_addr_in == 8'h07;
   endsequence
   sequence s_rd_ctrl;
      reg_rd_in && !reg_wr_in && reg_addr_in == 8'h07;
   endsequence
   // bit 7 may self-clear, so only the stored bits are compared
   a_ctrl_readback: assert property (s_wr_ctrl ##1 !reg_wr_in ##1 s_rd_ctrl |=>
      reg_rdata_out[6:0] == $past(reg_wdata_in[6:0], 3)) else $error("control readback wrong");
   a_rvalid_exact: assert property ($past(rst_b_in) |-> reg_rvalid_out == $past(reg_rd_in))
      else $error("read valid not one cycle after strobe");
   a_status_live: assert property (reg_rd_in && reg_addr_in == 8'h08 |=> reg_rdata_out ==
      $past({input_source_status_in, charge_state_in, input_limit_active_in, input_power_good_in,
      thermal_regulation_active_in, min_system_regulation_active_in})) else $error("status read wrong");
   a_fault_rsvd: assert property (reg_rd_in && reg_addr_in == 8'h09 |=> !reg_rdata_out[2])
      else $error("fault reserved bit set");
   a_tick_source: assert property (safety_tick_out |-> $past(safety_tick_in))
      else $error("tick out without tick in");
   a_detect_power: assert property (detect_start_out |-> $past(vbus_present_in))
      else $error("detection started without input power");
   // the control bit lands one edge after the write and the switch stage registers it once more
   a_switch_allow: assert property (reg_wr_in && reg_addr_in == 8'h07 && !reg_wdata_in[5] |->
      ##2 battery_switch_on_out) else $error("battery switch not allowed on");
   a_thresh_follow: assert property ($past(rst_b_in) |-> temp_threshold_boost_out == $past(boost_mode_in))
      else $error("threshold select not following mode");
endmodule // charger_regs_monitor

bind charger_status_fault_regs charger_regs_monitor u_mon (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
   .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .vbus_present_in(vbus_present_in),
   .detect_start_out(detect_start_out), .safety_tick_in(safety_tick_in), .safety_tick_out(safety_tick_out),
   .input_source_status_in(input_source_status_in), .charge_state_in(charge_state_in),
   .input_limit_active_in(input_limit_active_in), .input_power_good_in(input_power_good_in),
   .thermal_regulation_active_in(thermal_regulation_active_in),
   .min_system_regulation_active_in(min_system_regulation_active_in), .boost_mode_in(boost_mode_in),
   .temp_threshold_boost_out(temp_threshold_boost_out), .battery_switch_on_out(battery_switch_on_out));

//--- dv/host_model.sv
// host side model driving the byte register port
module host_model (
   input wire logic mclk_in,
   input wire logic [7:0] reg_rdata_in,
   input wire logic reg_rvalid_in,
   output logic [7:0] reg_addr_out = 8'h00,
   output logic reg_wr_out = 1'b0,
   output logic reg_rd_out = 1'b0,
   output logic [7:0] reg_wdata_out = 8'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   // called at a clock edge; released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= 1'b1;
      @(posedge mclk_in);
      reg_wr_out <= 1'b0;
      reg_addr_out <= ~a;
      reg_wdata_out <= ~d;
      @(posedge mclk_in);
   endtask
   // one strobe per read, never a burst, so a fault read clears once
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(posedge mclk_in);
      reg_rd_out <= 1'b0;
      reg_addr_out <= ~a;
      @(posedge mclk_in);
      d = reg_rdata_in;
      v = reg_rvalid_in;
   endtask
endmodule // host_model

//--- dv/test_charger_status_fault_regs.sv
// self-checking bench for the charger register block
module test_charger_status_fault_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_in = 1'b0, rst_b = 1'b0, vbus = 1'b1, done = 1'b0, tick = 1'b0, lim = 1'b0, pg = 1'b0;
   logic therm = 1'b0, minsys = 1'b0, wdog = 1'b0, boost = 1'b0, ovp = 1'b0, cold = 1'b0, hot = 1'b0;
   logic bmode = 1'b0, adrem = 1'b0, wr, rd, rvalid, det, tick_o, thr, sw_on, irq;
   logic [1:0] src = 2'h0, chg = 2'h0, code = 2'h0;
   logic [7:0] addr, wdata, rdata;
   int err_count = 0, checks_done = 0, cycles = 0, irq_cnt = 0, tick_cnt = 0, det_cnt = 0;
   // counters are only read against a snapshot, never cleared, so the edge process cannot race a reset
   int irq_base = 0, tick_base = 0, det_base = 0;
   // short turn-off delay keeps the run brief
   charger_status_fault_regs #(.BATTERY_SWITCH_OFF_DELAY_CYCLES(32'h0000_0014)) dut (.mclk_in(mclk_in),
      .rst_b_in(rst_b), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .vbus_present_in(vbus), .detect_done_in(done),
      .detect_start_out(det), .safety_tick_in(tick), .safety_tick_out(tick_o), .input_source_status_in(src),
      .charge_state_in(chg), .input_limit_active_in(lim), .input_power_good_in(pg),
      .thermal_regulation_active_in(therm), .min_system_regulation_active_in(minsys),
      .watchdog_expired_in(wdog), .boost_fault_in(boost), .charge_fault_code_in(code),
      .battery_overvoltage_in(ovp), .temp_cold_in(cold), .temp_hot_in(hot), .boost_mode_in(bmode),
      .adapter_removed_in(adrem), .temp_threshold_boost_out(thr), .battery_switch_on_out(sw_on),
      .fault_irq_out(irq));
   host_model host (.mclk_in(mclk_in), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid), .reg_addr_out(addr),
      .reg_wr_out(wr), .reg_rd_out(rd), .reg_wdata_out(wdata));
   initial
   begin
      forever #5 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in)
   begin
      cycles <= cycles + 1;
      irq_cnt <= irq_cnt + int'(irq);
      tick_cnt <= tick_cnt + int'(tick_o);
      det_cnt <= det_cnt + int'(det);
      if (cycles == 5000)
      begin
         err_count++;
         test_done;
      end
   end
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checks_done++;
      if (s !== e)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic v;
      host.rd(a, d, v);
      chk({n, " valid"}, 8'h01, {7'h00, v});
      chk(n, e, d);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   task automatic t_reset;
      rdc("ctrl reset", 8'h07, 8'h4b);
      rdc("fault reset", 8'h09, 8'h00);
      chk("switch reset", 8'h01, {7'h00, sw_on});
      rdc("unmapped", 8'h0a, 8'h00);
      host.wr(8'h08, 8'hff);
      rdc("ctrl kept", 8'h07, 8'h4b);
   endtask
   task automatic t_status;
      for (int i = 0; i < 4; i++)
      begin
         src <= i[1:0];
         chg <= 2'(3 - i);
         lim <= i[0];
         pg <= i[1];
         therm <= ~i[0];
         minsys <= ~i[1];
         cyc(1);
         rdc("status", 8'h08, {i[1:0], 2'(3 - i), i[0], i[1], ~i[0], ~i[1]});
      end
   endtask
   // a fault shown for one cycle must still be read back, then cleared
   task automatic t_faults;
      for (int c = 1; c < 4; c++)
      begin
         code <= 2'(c);
         cyc(1);
         code <= 2'h0;
         cyc(2);
         rdc("charge code", 8'h09, {2'h0, 2'(c), 4'h0});
      end
      irq_base = irq_cnt;
      {wdog, boost, code, ovp, cold, hot} <= 7'h77;
      cyc(1);
      {wdog, boost, code, ovp, cold, hot} <= 7'h00;
      cyc(2);
      rdc("fault all", 8'h09, 8'heb);
      rdc("fault cleared", 8'h09, 8'h00);
      chk("irq count", 8'h01, 8'(irq_cnt - irq_base));
      wdog <= 1'b1;
      cyc(1);
      rdc("held 1", 8'h09, 8'h80);
      rdc("held 2", 8'h09, 8'h80);
      wdog <= 1'b0;
      bmode <= 1'b1;
      cyc(2);
      chk("threshold", 8'h01, {7'h00, thr});
      rdc("held 3", 8'h09, 8'h80);
      rdc("held 4", 8'h09, 8'h00);
   endtask
   task automatic t_mask;
      host.wr(8'h07, 8'h48);
      rdc("ctrl masked", 8'h07, 8'h48);
      irq_base = irq_cnt;
      {code, ovp} <= 3'h3;
      cyc(1);
      {code, ovp} <= 3'h0;
      cyc(2);
      chk("masked irq", 8'h00, 8'(irq_cnt - irq_base));
      rdc("masked fault", 8'h09, 8'h18);
      host.wr(8'h07, 8'h4b);
      for (int k = 0; k < 2; k++)
      begin
         irq_base = irq_cnt;
         {code, ovp} <= k ? 3'h6 : 3'h1;
         cyc(1);
         {code, ovp} <= 3'h0;
         cyc(2);
         chk("enabled irq", 8'h01, 8'(irq_cnt - irq_base));
         rdc("enabled fault", 8'h09, k ? 8'h30 : 8'h08);
      end
   endtask
   task automatic t_adapter;
      adrem <= 1'b1;
      cyc(1);
      adrem <= 1'b0;
      cyc(2);
      rdc("unplug", 8'h09, 8'h10);
      rdc("unplug once", 8'h09, 8'h00);
   endtask
   task automatic t_detect;
      vbus <= 1'b0;
      det_base = det_cnt;
      host.wr(8'h07, 8'hcb);
      cyc(6);
      chk("no power detect", 8'h00, 8'(det_cnt - det_base));
      vbus <= 1'b1;
      cyc(6);
      chk("detect start", 8'h01, 8'(det_cnt - det_base));
      rdc("detect pending", 8'h07, 8'hcb);
      done <= 1'b1;
      cyc(1);
      done <= 1'b0;
      cyc(1);
      rdc("detect cleared", 8'h07, 8'h4b);
   endtask
   task automatic ticks(input int e);
      tick_base = tick_cnt;
      repeat (4)
      begin
         tick <= 1'b1;
         cyc(1);
         tick <= 1'b0;
         cyc(2);
      end
      chk("ticks", 8'(e), 8'(tick_cnt - tick_base));
   endtask
   task automatic t_timer;
      {lim, therm} <= 2'h2;
      ticks(2);
      {lim, therm} <= 2'h1;
      ticks(2);
      {lim, therm} <= 2'h0;
      ticks(4);
      host.wr(8'h07, 8'h0b);
      lim <= 1'b1;
      ticks(4);
      lim <= 1'b0;
   endtask
   task automatic t_switch;
      host.wr(8'h07, 8'h6b);
      cyc(5);
      chk("switch delayed", 8'h01, {7'h00, sw_on});
      cyc(30);
      chk("switch off", 8'h00, {7'h00, sw_on});
      host.wr(8'h07, 8'h4b);
      // switch stage registers the cleared bit one edge after the control register
      cyc(1);
      chk("switch allowed", 8'h01, {7'h00, sw_on});
   endtask
   initial
   begin
      cyc(16);
      rst_b <= 1'b1;
      cyc(1);
      t_reset;
      t_status;
      t_faults;
      t_mask;
      t_adapter;
      t_detect;
      t_timer;
      t_switch;
      test_done;
   end
endmodule // test_charger_status_fault_regs
